//--- hdl/sac_map.vh
// Register indices, field positions, reset values and resolution codes of the converter control
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
// Register indices (byte address is four times the index)
`define SAC_IDX_SC1 14'h0010
`define SAC_IDX_SC2 14'h0011
`define SAC_IDX_SC3 14'h0012
`define SAC_IDX_SC4 14'h0013
`define SAC_IDX_RH 14'h0014
`define SAC_IDX_RL 14'h0015
`define SAC_IDX_CVH 14'h0016
`define SAC_IDX_CVL 14'h0017
`define SAC_IDX_IST 14'h0018
`define SAC_IDX_IMSK 14'h0019
`define SAC_IDX_PC1 14'h30ac
`define SAC_IDX_PC2 14'h30ad
// Reset values
`define SAC_RST_SC1 8'h1f
`define SAC_RST_SC2 8'h08
`define SAC_RST_ZERO 8'h00
// First control register fields
`define SAC_SC1_DONE 7
`define SAC_SC1_IEN 6
`define SAC_SC1_CONT 5
`define SAC_CHAN_OFF 5'h1f
// Second control register fields
`define SAC_SC2_ACT 7
`define SAC_SC2_TRIG 6
`define SAC_SC2_CMPEN 5
`define SAC_SC2_CMPGE 4
// Third control register fields
`define SAC_SC3_LP 7
`define SAC_SC3_DIV_HI 6
`define SAC_SC3_DIV_LO 5
`define SAC_SC3_LSMP 4
`define SAC_SC3_MODE_HI 3
`define SAC_SC3_MODE_LO 2
`define SAC_SC3_CLK_HI 1
`define SAC_SC3_CLK_LO 0
// Resolution codes
`define SAC_MODE_8 2'h0
`define SAC_MODE_12 2'h1
`define SAC_MODE_10 2'h2
// Clock source used in low-power modes
`define SAC_CLK_ASYNC 2'h3
// Queue geometry
`define SAC_QDEPTH 8
`define SAC_DEPTH_HI 2
// Interrupt status bits
`define SAC_IST_DONE 0
`define SAC_IST_CMP 1
`endif

//--- hdl/sac_top.v
// Successive-approximation converter control: register bank, channel queue, result queue, compare
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "sac_map.vh"
//
// Contract
// [RULE1] Control-one write aborts, restarts unless channel off
// [RULE2] Queued channels convert in written order
// [RULE3] Queue start waits for programmed depth
// [RULE4] Channel all-ones empties queue, halts conversion
// [RULE5] Results right-justified at 8/10/12 bits
// [RULE6] Single or continuous; single returns idle
// [RULE7] Result queue up to eight, depth selectable
// [RULE8] Compare less-than or greater-equal, may interrupt
// [RULE9] Done flag set, interrupt on completion
// [RULE10] Clock source picked from four options
// [RULE11] Synchronised hardware trigger can start conversions
// [RULE12] Keeps converting in wait and deep stop
// [RULE13] Channel field selects among analog inputs
// [RULE14] Sample time and speed/power configurable
// [RULE15] Done clears on control-one write, low read
// [RULE16] Active bit set on start, cleared end/abort
// [RULE17] Hardware mode starts on trigger, not write
// [RULE18] Done with enable high asserts interrupt
// [RULE19] Reset leaves registers at reset, nothing active
module sac_top (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [15:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire [31:0] prdata_o,
    output wire pslverr_o,
    // Converter core
    output reg conv_start_o,
    output reg conv_abort_o,
    output reg [4:0] conv_chan_o,
    input wire conv_done_i,
    input wire [11:0] conv_data_i,
    output wire [1:0] conv_mode_o,
    output wire conv_long_sample_o,
    output wire conv_low_power_o,
    output wire [1:0] conv_clk_div_o,
    output wire [1:0] conv_clk_sel_o,
    output wire [15:0] pin_enable_o,
    // System
    input wire hw_trig_i,
    input wire wait_mode_i,
    input wire deep_stop_i,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers and state

reg [7:0] sc1_q; // Channel, continuous, enable (done kept apart)
reg done_q; // Conversion done flag
reg [7:0] sc2_q; // Trigger, compare controls (active kept apart)
reg active_q; // Conversion active
reg [7:0] sc3_q; // Clock, mode, sample
reg [7:0] sc4_q; // Queue depth
reg [7:0] cvh_q; // Compare value high
reg [7:0] cvl_q; // Compare value low
reg [7:0] pc1_q; // Pin enables low
reg [7:0] pc2_q; // Pin enables high
reg [1:0] ist_q; // Sticky interrupt status
reg [1:0] imsk_q; // Interrupt mask
reg [4:0] chq_q [0:`SAC_QDEPTH-1]; // Channel queue
reg [11:0] res_q [0:`SAC_QDEPTH-1]; // Result queue
reg [3:0] qcnt_q; // Channels queued
reg [2:0] idx_q; // Position in current set
reg [3:0] rcnt_q; // Results held
reg [2:0] rptr_q; // Result read pointer
reg armed_q; // Waiting for hardware trigger
reg cmp_acc_q; // Any compare hit in set
reg trig_s1_q; // Trigger sync stage one
reg trig_s2_q; // Trigger sync stage two
reg trig_s3_q; // Trigger edge history
reg [31:0] rdata_q; // Read data latched in setup
reg err_q; // Unmapped access latched in setup

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Right-justify a raw 12-bit core value to the chosen resolution
function [11:0] fmt_res;
    input [11:0] raw;
    input [1:0] mode;
    begin
        case (mode)
            `SAC_MODE_8: fmt_res = {4'h0, raw[11:4]};
            `SAC_MODE_10: fmt_res = {2'h0, raw[11:2]};
            default: fmt_res = raw;
        endcase
    end
endfunction

// Register index decode
function is_idx;
    input [15:0] addr;
    input [13:0] idx;
    begin
        is_idx = (addr[15:2] == idx) && (addr[1:0] == 2'h0);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire setup = psel_i & ~penable_i; // Setup phase of a transfer
wire access = psel_i & penable_i; // Access phase, always zero-wait
wire wr_en = access & pwrite_i; // Write takes effect
wire rd_en = access & ~pwrite_i; // Read completes
wire sc1_wr = wr_en & is_idx(paddr_i, `SAC_IDX_SC1);
wire rl_rd = rd_en & is_idx(paddr_i, `SAC_IDX_RL);
wire [4:0] wr_chan = pwdata_i[4:0];
wire chan_off = (wr_chan == `SAC_CHAN_OFF);

assign pready_o = access;
assign prdata_o = rdata_q;
assign pslverr_o = access & err_q;

////////////////////////////////////////////////////////////////////////////////
// Control decode

wire trig_hw = sc2_q[`SAC_SC2_TRIG];
wire cmp_en = sc2_q[`SAC_SC2_CMPEN];
wire cmp_ge = sc2_q[`SAC_SC2_CMPGE];
wire cont = sc1_q[`SAC_SC1_CONT];
wire [1:0] mode = sc3_q[`SAC_SC3_MODE_HI:`SAC_SC3_MODE_LO];
wire [2:0] depth_f = sc4_q[`SAC_DEPTH_HI:0];
wire fifo_en = (depth_f != 3'h0); // [RULE7]
wire [3:0] qdepth = {1'b0, depth_f} + 4'h1; // [RULE7]
wire [11:0] cmp_val = {cvh_q[3:0], cvl_q};
wire [11:0] res_now = fmt_res(conv_data_i, mode); // [RULE5]
wire cmp_now = cmp_ge ? (res_now >= cmp_val) : (res_now < cmp_val); // [RULE8]
wire hw_edge = trig_s2_q & ~trig_s3_q;

// Queue reaches programmed depth with this write
wire qfill = fifo_en & sc1_wr & ~chan_off & ((qcnt_q + 4'h1) == qdepth); // [RULE3]
// Software start: a write, or the queue filling
wire sw_go = sc1_wr & ~chan_off & ~trig_hw & (~fifo_en | qfill); // [RULE1]
// Hardware start: armed and a rising trigger edge
wire hw_go = ~sc1_wr & trig_hw & armed_q & ~active_q & hw_edge; // [RULE17]
wire go = sw_go | hw_go;
// Core completion, ignored when aborted by a write in the same cycle
wire done_ev = conv_done_i & active_q & ~sc1_wr;
wire last = ~fifo_en | ({1'b0, idx_q} + 4'h1 == qdepth);
wire next_in_set = done_ev & ~last; // [RULE2]
wire restart = done_ev & last & cont & ~trig_hw; // [RULE6]
wire set_end = done_ev & last;
wire done_set = set_end & (~cmp_en | cmp_acc_q | cmp_now); // [RULE9]
wire [2:0] idx_nx = idx_q + 3'h1;

////////////////////////////////////////////////////////////////////////////////
// Outputs to the converter core

assign conv_mode_o = mode; // [RULE5]
assign conv_long_sample_o = sc3_q[`SAC_SC3_LSMP]; // [RULE14]
assign conv_low_power_o = sc3_q[`SAC_SC3_LP]; // [RULE14]
assign conv_clk_div_o = sc3_q[`SAC_SC3_DIV_HI:`SAC_SC3_DIV_LO]; // [RULE14]
// Low-power modes fall back on the asynchronous source so conversion continues
assign conv_clk_sel_o = (wait_mode_i | deep_stop_i) ? `SAC_CLK_ASYNC :
                        sc3_q[`SAC_SC3_CLK_HI:`SAC_SC3_CLK_LO]; // [RULE10] [RULE12]
assign pin_enable_o = {pc2_q, pc1_q};

// Interrupt: done with enable, or any unmasked sticky event
assign irq_o = (done_q & sc1_q[`SAC_SC1_IEN]) | (|(ist_q & imsk_q)); // [RULE18]

////////////////////////////////////////////////////////////////////////////////
// Hardware trigger synchroniser

// Two stages, then an edge history stage
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        trig_s1_q <= 1'b0;
        trig_s2_q <= 1'b0;
        trig_s3_q <= 1'b0;
    end else begin
        trig_s1_q <= hw_trig_i; // [RULE11]
        trig_s2_q <= trig_s1_q;
        trig_s3_q <= trig_s2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Plain read/write registers

// Software-written configuration
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        sc1_q <= `SAC_RST_SC1; // [RULE19]
        sc2_q <= `SAC_RST_SC2;
        sc3_q <= `SAC_RST_ZERO;
        sc4_q <= `SAC_RST_ZERO;
        cvh_q <= `SAC_RST_ZERO;
        cvl_q <= `SAC_RST_ZERO;
        pc1_q <= `SAC_RST_ZERO;
        pc2_q <= `SAC_RST_ZERO;
        imsk_q <= 2'h0;
    end else if (wr_en) begin
        // Channel field steers input selection
        if (is_idx(paddr_i, `SAC_IDX_SC1)) begin
            sc1_q <= {1'b0, pwdata_i[6:0]}; // [RULE13]
        end
        if (is_idx(paddr_i, `SAC_IDX_SC2)) begin
            sc2_q <= {1'b0, pwdata_i[6:0]};
        end
        if (is_idx(paddr_i, `SAC_IDX_SC3)) begin
            sc3_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_SC4)) begin
            sc4_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_CVH)) begin
            cvh_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_CVL)) begin
            cvl_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_PC1)) begin
            pc1_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_PC2)) begin
            pc2_q <= pwdata_i[7:0];
        end
        if (is_idx(paddr_i, `SAC_IDX_IMSK)) begin
            imsk_q <= pwdata_i[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion sequencer

// Start, abort, queue walk and continuous looping
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        active_q <= 1'b0; // [RULE19]
        armed_q <= 1'b0;
        idx_q <= 3'h0;
        qcnt_q <= 4'h0;
        cmp_acc_q <= 1'b0;
        conv_start_o <= 1'b0;
        conv_abort_o <= 1'b0;
        conv_chan_o <= `SAC_CHAN_OFF;
    end else begin
        conv_start_o <= 1'b0;
        conv_abort_o <= 1'b0;
        if (sc1_wr) begin
            // Any write stops what is running
            conv_abort_o <= active_q; // [RULE1]
            active_q <= 1'b0; // [RULE16]
            if (chan_off) begin
                // Channel off: empty queue and disarm
                qcnt_q <= 4'h0; // [RULE4]
                armed_q <= 1'b0; // [RULE4]
            end else if (fifo_en) begin
                // Queue the channel in write order
                if (qcnt_q < qdepth) begin
                    chq_q[qcnt_q[2:0]] <= wr_chan; // [RULE2]
                    qcnt_q <= qcnt_q + 4'h1;
                end
                armed_q <= qfill & trig_hw; // [RULE17]
            end else begin
                armed_q <= trig_hw; // [RULE17]
            end
        end
        if (go) begin
            // Begin a conversion or a set
            active_q <= 1'b0 | 1'b1; // [RULE16]
            conv_start_o <= 1'b1;
            idx_q <= 3'h0;
            cmp_acc_q <= 1'b0;
            conv_chan_o <= fifo_en ? chq_q[0] : (sw_go ? wr_chan : sc1_q[4:0]); // [RULE13]
        end else if (next_in_set) begin
            // Next queued channel in order
            conv_start_o <= 1'b1;
            idx_q <= idx_nx;
            cmp_acc_q <= cmp_acc_q | cmp_now;
            conv_chan_o <= chq_q[idx_nx]; // [RULE2]
        end else if (restart) begin
            // Continuous software mode loops at once
            conv_start_o <= 1'b1; // [RULE6]
            idx_q <= 3'h0;
            cmp_acc_q <= 1'b0;
            conv_chan_o <= fifo_en ? chq_q[0] : sc1_q[4:0];
        end else if (set_end) begin
            // Hardware continuous waits for next edge; single goes idle
            active_q <= 1'b0; // [RULE16]
            cmp_acc_q <= 1'b0;
            armed_q <= cont & trig_hw; // [RULE6]
            if (fifo_en & ~cont) begin
                qcnt_q <= 4'h0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Result queue

// Results land by set position; low-byte read advances the pointer
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rcnt_q <= 4'h0;
        rptr_q <= 3'h0;
    end else if (sc1_wr & chan_off) begin
        rcnt_q <= 4'h0; // [RULE4]
        rptr_q <= 3'h0;
    end else if (done_ev) begin
        res_q[fifo_en ? idx_q : 3'h0] <= res_now; // [RULE7]
        rcnt_q <= fifo_en ? ({1'b0, idx_q} + 4'h1) : 4'h1;
        rptr_q <= 3'h0;
    end else if (rl_rd && ({1'b0, rptr_q} + 4'h1 < rcnt_q)) begin
        rptr_q <= rptr_q + 3'h1; // [RULE7]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flags

// Done flag and sticky status; a set wins over a same-cycle clear
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        done_q <= 1'b0;
        ist_q <= 2'h0;
    end else begin
        done_q <= done_set | (done_q & ~(sc1_wr | rl_rd)); // [RULE9] [RULE15]
        ist_q[`SAC_IST_DONE] <= done_set |
            (ist_q[`SAC_IST_DONE] & ~(wr_en & is_idx(paddr_i, `SAC_IDX_IST) & pwdata_i[`SAC_IST_DONE]));
        ist_q[`SAC_IST_CMP] <= (done_ev & cmp_en & cmp_now) |
            (ist_q[`SAC_IST_CMP] & ~(wr_en & is_idx(paddr_i, `SAC_IDX_IST) & pwdata_i[`SAC_IST_CMP])); // [RULE8]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read path

// Data captured in setup, presented through the access phase
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rdata_q <= 32'h0000_0000;
        err_q <= 1'b0;
    end else if (setup) begin
        err_q <= 1'b0;
        rdata_q <= 32'h0000_0000;
        case (paddr_i[15:2])
            `SAC_IDX_SC1: rdata_q[7:0] <= {done_q, sc1_q[6:0]}; // [RULE9]
            `SAC_IDX_SC2: rdata_q[7:0] <= {active_q, sc2_q[6:0]}; // [RULE16]
            `SAC_IDX_SC3: rdata_q[7:0] <= sc3_q;
            `SAC_IDX_SC4: rdata_q[7:0] <= sc4_q;
            `SAC_IDX_RH: rdata_q[7:0] <= (rcnt_q != 4'h0) ? {4'h0, res_q[rptr_q][11:8]} : 8'h00;
            `SAC_IDX_RL: rdata_q[7:0] <= (rcnt_q != 4'h0) ? res_q[rptr_q][7:0] : 8'h00;
            `SAC_IDX_CVH: rdata_q[7:0] <= cvh_q;
            `SAC_IDX_CVL: rdata_q[7:0] <= cvl_q;
            `SAC_IDX_IST: rdata_q[1:0] <= ist_q;
            `SAC_IDX_IMSK: rdata_q[1:0] <= imsk_q;
            `SAC_IDX_PC1: rdata_q[7:0] <= pc1_q;
            `SAC_IDX_PC2: rdata_q[7:0] <= pc2_q;
            default: err_q <= 1'b1;
        endcase
        if (paddr_i[1:0] != 2'h0) begin
            err_q <= 1'b1;
            // Refused reads return zero even if the index matches
            rdata_q <= 32'h0000_0000;
        end
    end
end

endmodule

//--- verif/sac_core_model.sv
// Behavioural converter core: one answer per start after a set delay
`timescale 1ns/1ns
module sac_core_model (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Requests and answers
    input wire conv_start_i,
    input wire conv_abort_i,
    input wire [4:0] conv_chan_i,
    input wire [7:0] delay_i,
    output reg conv_done_o,
    output reg [11:0] conv_data_o
);
    reg busy_q; // Conversion in flight
    reg [7:0] cnt_q; // Cycles left
    reg [4:0] chan_q; // Channel sampled
    // Data only valid with the done pulse, so it flips otherwise
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            chan_q <= 5'h00;
            conv_done_o <= 1'b0;
            conv_data_o <= 12'h000;
        end else begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~conv_data_o;
            if (conv_start_i) begin
                busy_q <= 1'b1;
                cnt_q <= delay_i;
                chan_q <= conv_chan_i;
            end else if (conv_abort_i) begin
                busy_q <= 1'b0;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                conv_done_o <= 1'b1;
                conv_data_o <= {chan_q, 7'h25};
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

//--- verif/sac_properties.sv
// Port-level assertions for the converter control
`timescale 1ns/1ns
`include "sac_map.vh"
module sac_properties (
    // Clock, reset and bus
    input wire clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
    input wire [15:0] paddr_i,
    input wire [31:0] pwdata_i, prdata_o,
    // Core side and system
    input wire conv_start_o, conv_abort_o, conv_done_i, wait_mode_i, deep_stop_i, irq_o,
    input wire [4:0] conv_chan_o,
    input wire [1:0] conv_clk_sel_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Access phase and writes to the first control register
    wire acc = psel_i && penable_i;
    wire sc1_wr = acc && pwrite_i && paddr_i == {`SAC_IDX_SC1, 2'b00};
    ////////////////////////////////////////////////////////////
    a_bus_zero_wait: assert property (psel_i && !penable_i ##1 acc |-> pready_o)
        else $error("access phase without ready");
    a_err_bad_align: assert property (acc && paddr_i[1:0] != 2'b00 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("misaligned access accepted");
    a_err_in_access: assert property (pslverr_o |-> acc)
        else $error("error outside an access phase");
    a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    a_abort_one_cycle: assert property (conv_abort_o |=> !conv_abort_o)
        else $error("abort pulse too long");
    a_off_no_start: assert property (sc1_wr && pwdata_i[4:0] == `SAC_CHAN_OFF |=> !conv_start_o [*2])
        else $error("start after channel off");
    a_start_chan_on: assert property (conv_start_o |-> conv_chan_o != `SAC_CHAN_OFF)
        else $error("start with channel off");
    a_clock_async_low: assert property (wait_mode_i || deep_stop_i |-> conv_clk_sel_o == `SAC_CLK_ASYNC)
        else $error("low power without async clock");
    a_irq_has_cause: assert property ($rose(irq_o) |-> $past(conv_done_i) || $past(acc && pwrite_i))
        else $error("interrupt without cause");
    // Main scenarios reached
    c_sc1_write: cover property (sc1_wr);
    c_start: cover property (conv_start_o);
    c_irq: cover property (irq_o);
    c_err: cover property (pslverr_o);
endmodule
bind sac_top sac_properties i_props (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o,
    .paddr_i, .pwdata_i, .prdata_o, .conv_start_o, .conv_abort_o, .conv_done_i, .wait_mode_i, .deep_stop_i,
    .irq_o, .conv_chan_o, .conv_clk_sel_o);

//--- verif/testbench.sv
// Self-checking bench for the converter control
`timescale 1ns/1ns
`include "sac_map.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
    // Design inputs
    reg clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg hw_trig_i = 0, wait_mode_i = 0, deep_stop_i = 0;
    reg [15:0] paddr_i = 0;
    reg [31:0] pwdata_i = 0;
    reg [7:0] dly = 8'd20;
    // Design outputs and core answers
    wire pready_o, pslverr_o, conv_start_o, conv_abort_o, conv_long_sample_o, conv_low_power_o, irq_o, conv_done_i;
    wire [31:0] prdata_o;
    wire [4:0] conv_chan_o;
    wire [11:0] conv_data_i;
    wire [1:0] conv_mode_o, conv_clk_div_o, conv_clk_sel_o;
    wire [15:0] pin_enable_o;
    // Bookkeeping
    int mismatches = 0, check_count = 0, starts = 0, aborts = 0, i, j, k, s;
    reg [4:0] log_q[$];
    reg [31:0] r;
    reg e;
    reg [1:0] mis = 2'h0; // Low address bits, nonzero only for refused accesses
    reg [11:0] x;
    reg [13:0] ridx [0:9] = '{`SAC_IDX_SC1, `SAC_IDX_SC2, `SAC_IDX_SC3, `SAC_IDX_SC4, `SAC_IDX_RH,
        `SAC_IDX_RL, `SAC_IDX_CVH, `SAC_IDX_CVL, `SAC_IDX_PC1, `SAC_IDX_PC2};
    reg [1:0] mds [0:2] = '{`SAC_MODE_8, `SAC_MODE_10, `SAC_MODE_12};
    reg [4:0] chs [0:2] = '{5'd5, 5'd9, 5'd23};
    always #5 clk_i = ~clk_i;
    sac_top i_dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o,
        .pslverr_o, .conv_start_o, .conv_abort_o, .conv_chan_o, .conv_done_i, .conv_data_i, .conv_mode_o,
        .conv_long_sample_o, .conv_low_power_o, .conv_clk_div_o, .conv_clk_sel_o, .pin_enable_o, .hw_trig_i,
        .wait_mode_i, .deep_stop_i, .irq_o);
    sac_core_model i_core (.clk_i, .arst_n_i, .conv_start_i(conv_start_o), .conv_abort_i(conv_abort_o),
        .conv_chan_i(conv_chan_o), .delay_i(dly), .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
    // Log of every start and its channel
    always @(posedge clk_i) begin
        if (conv_start_o === 1'b1) begin
            starts++;
            log_q.push_back(conv_chan_o);
        end
        if (conv_abort_o === 1'b1) aborts++;
    end
    ////////////////////////////////////////////////////////////
    // One bus transfer, held until ready is sampled high
    task automatic xfer(input bit w, input [13:0] idx, input [7:0] d);
        int t;
        t = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {idx, mis};
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && t < 20) begin
            t++;
            @(posedge clk_i);
        end
        if (t == 20) mismatches++;
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input [13:0] idx, input [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task rd(input [13:0] idx, input [7:0] ex, input string nm);
        xfer(1'b0, idx, 8'h00);
        `CHK(nm, {24'h0, ex}, r)
    endtask
    // Poll the active bit until the conversion ends
    task wait_idle;
        xfer(1'b0, `SAC_IDX_SC2, 8'h00);
        for (j = 0; j < 40 && r[7] !== 1'b0; j++) xfer(1'b0, `SAC_IDX_SC2, 8'h00);
        if (j == 40) mismatches++;
    endtask
    task wait_starts(input int m);
        for (k = 0; k < 300 && starts < m; k++) @(posedge clk_i);
    endtask
    // Expected right-justified result of the model's raw value
    function [11:0] res(input [4:0] ch, input [1:0] m);
        res = {ch, 7'h25};
        if (m == `SAC_MODE_8) res = res >> 4;
        if (m == `SAC_MODE_10) res = res >> 2;
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 10; i++) rd(ridx[i], i == 0 ? `SAC_RST_SC1 : i == 1 ? `SAC_RST_SC2 : `SAC_RST_ZERO, "reset");
        `CHK("idle channel", `SAC_CHAN_OFF, conv_chan_o)
        xfer(1'b0, 14'h0020, 8'h00);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0000_0000, r)
        mis = 2'h1;
        xfer(1'b0, `SAC_IDX_SC1, 8'h00);
        mis = 2'h0;
        `CHK("misaligned err", 1'b1, e)
        `CHK("misaligned data", 32'h0000_0000, r)
        wr(`SAC_IDX_RL, 8'hff);
        rd(`SAC_IDX_RL, 8'h00, "read only");
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            wr(`SAC_IDX_SC3, {4'h0, mds[i], 2'h0});
            wr(`SAC_IDX_SC1, {3'h0, chs[i]});
            rd(`SAC_IDX_SC2, 8'h88, "active");
            wait_idle;
            rd(`SAC_IDX_SC1, {3'h4, chs[i]}, "done");
            x = res(chs[i], mds[i]);
            rd(`SAC_IDX_RH, {4'h0, x[11:8]}, "result high");
            rd(`SAC_IDX_RL, x[7:0], "result low");
            rd(`SAC_IDX_SC1, {3'h0, chs[i]}, "done cleared");
            `CHK("channel", chs[i], log_q[$])
        end
        $display("test single done");
        wr(`SAC_IDX_SC1, 8'h43);
        wait_idle;
        `CHK("irq on done", 1'b1, irq_o)
        xfer(1'b0, `SAC_IDX_RL, 8'h00);
        `CHK("irq after read", 1'b0, irq_o)
        rd(`SAC_IDX_IST, 8'h01, "status");
        wr(`SAC_IDX_IMSK, 8'h01);
        `CHK("irq unmasked", 1'b1, irq_o)
        wr(`SAC_IDX_IST, 8'h01);
        `CHK("irq cleared", 1'b0, irq_o)
        $display("test interrupt done");
        s = starts;
        wr(`SAC_IDX_SC1, 8'h07);
        wr(`SAC_IDX_SC1, 8'h1f);
        rd(`SAC_IDX_SC2, 8'h08, "halted");
        wr(`SAC_IDX_SC1, 8'h07);
        wr(`SAC_IDX_SC1, 8'h09);
        wait_idle;
        `CHK("restart count", s + 3, starts)
        `CHK("abort count", 2, aborts)
        x = res(5'd9, `SAC_MODE_12);
        rd(`SAC_IDX_RL, x[7:0], "restart result");
        dly <= 8'd2;
        s = starts;
        wr(`SAC_IDX_SC1, 8'h24);
        wait_starts(s + 3);
        `CHK("continuous", 1'b1, starts >= s + 3)
        wr(`SAC_IDX_SC1, 8'h1f);
        dly <= 8'd20;
        $display("test abort and continuous done");
        wr(`SAC_IDX_CVH, 8'h01);
        wr(`SAC_IDX_SC2, 8'h20);
        wr(`SAC_IDX_SC1, 8'h02);
        wait_idle;
        rd(`SAC_IDX_SC1, 8'h02, "less than false");
        wr(`SAC_IDX_SC2, 8'h30);
        wr(`SAC_IDX_SC1, 8'h02);
        wait_idle;
        rd(`SAC_IDX_SC1, 8'h82, "greater equal true");
        rd(`SAC_IDX_IST, 8'h03, "compare status");
        wr(`SAC_IDX_IST, 8'h03);
        wr(`SAC_IDX_SC2, 8'h00);
        $display("test compare done");
        wr(`SAC_IDX_SC4, 8'h02);
        s = starts;
        wr(`SAC_IDX_SC1, 8'h01);
        wr(`SAC_IDX_SC1, 8'h02);
        repeat (5) @(posedge clk_i);
        `CHK("queue waits", s, starts)
        wr(`SAC_IDX_SC1, 8'h03);
        wait_starts(s + 3);
        wait_idle;
        for (i = 0; i < 3; i++) begin
            `CHK("queue order", 5'(i + 1), log_q[s + i])
            x = res(5'(i + 1), `SAC_MODE_12);
            rd(`SAC_IDX_RH, {4'h0, x[11:8]}, "queued high");
            rd(`SAC_IDX_RL, x[7:0], "queued low");
        end
        wr(`SAC_IDX_SC1, 8'h1f);
        wr(`SAC_IDX_SC4, 8'h00);
        $display("test queue done");
        wr(`SAC_IDX_SC2, 8'h40);
        s = starts;
        wr(`SAC_IDX_SC1, 8'h04);
        repeat (5) @(posedge clk_i);
        `CHK("no write start", s, starts)
        hw_trig_i <= 1'b1;
        wait_starts(s + 1);
        `CHK("trigger start", s + 1, starts)
        hw_trig_i <= 1'b0;
        wait_idle;
        wr(`SAC_IDX_SC2, 8'h00);
        $display("test trigger done");
        wr(`SAC_IDX_SC3, 8'hd2);
        `CHK("clock select", 2'h2, conv_clk_sel_o)
        `CHK("speed power", 4'hd, {conv_low_power_o, conv_clk_div_o, conv_long_sample_o})
        `CHK("mode out", `SAC_MODE_8, conv_mode_o)
        deep_stop_i <= 1'b1;
        @(posedge clk_i);
        `CHK("stop clock", `SAC_CLK_ASYNC, conv_clk_sel_o)
        wr(`SAC_IDX_SC1, 8'h06);
        wait_idle;
        x = res(5'd6, `SAC_MODE_8);
        rd(`SAC_IDX_RL, x[7:0], "stop result");
        deep_stop_i <= 1'b0;
        wait_mode_i <= 1'b1;
        @(posedge clk_i);
        `CHK("wait clock", `SAC_CLK_ASYNC, conv_clk_sel_o)
        wait_mode_i <= 1'b0;
        wr(`SAC_IDX_PC1, 8'ha5);
        wr(`SAC_IDX_PC2, 8'h3c);
        `CHK("pins", 16'h3ca5, pin_enable_o)
        $display("test low power done");
        complete_run;
    end
endmodule
